// File: design/acdp_pkg.sv
// constants, types and field layout of the adc decimator pair config block
package acdp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register port
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] OFS_PAIR23 = 8'h1C;
  localparam logic [7:0] OFS_PAIR01 = 8'h1D;
  localparam logic [7:0] RST_PAIR23 = 8'h19;
  localparam logic [7:0] RST_PAIR01 = 8'h00;
  localparam logic [7:0] RDATA_NONE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // field positions, second pair register
  localparam int unsigned P23_SINC    = 5;
  localparam int unsigned P23_MUTE3   = 4;
  localparam int unsigned P23_MUTE2   = 3;
  localparam int unsigned P23_RATE_LO = 0;

  // field positions, first pair register
  localparam int unsigned P01_HP_LO = 5;
  localparam int unsigned P01_POL   = 4;
  localparam int unsigned P01_SWAP  = 3;
  localparam int unsigned P01_SRC   = 2;
  localparam int unsigned P01_EN1   = 1;
  localparam int unsigned P01_EN0   = 0;

  ////////////////////////////////////////////////////////////////////////////
  // encodings
  typedef enum logic [1:0] {
    RATE_96K  = 2'h0,
    RATE_192K = 2'h1,
    RATE_768K = 2'h2,
    RATE_RSVD = 2'h3
  } acdp_rate_t;

  typedef enum logic [1:0] {
    HP_OFF = 2'h0,
    HP_1HZ = 2'h1,
    HP_4HZ = 2'h2,
    HP_8HZ = 2'h3
  } acdp_hp_t;

  typedef enum {
    RAMP_OFF,
    RAMP_RUN,
    RAMP_HOLD
  } acdp_ramp_st_t;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned FS_96_HZ   = 96_000;
  localparam int unsigned FS_192_HZ  = 192_000;
  localparam int unsigned FS_768_HZ  = 768_000;
  localparam logic [7:0]  DIV_96     = 8'(CLK_HZ / FS_96_HZ);
  localparam logic [7:0]  DIV_192    = 8'(CLK_HZ / FS_192_HZ);
  localparam logic [7:0]  DIV_768    = 8'(CLK_HZ / FS_768_HZ);
  localparam logic [3:0]  RAMP_LAST  = 4'hF;   // 16 sample periods a step
  localparam logic [7:0]  VOL_MUTE   = 8'hFF;  // -95.625 dB
  localparam logic [7:0]  VOL_UNITY  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // settings in force on the decimators
  typedef struct packed {
    logic       sinc_third;
    acdp_rate_t rate;
  } acdp_pair23_t;

  typedef struct packed {
    acdp_hp_t   hp;
    logic       mic_source;
    logic [1:0] adc_en;
  } acdp_pair01_t;

endpackage

// File: design/acdp_vol_ramp.sv
// volume ramp of one decimator channel, in attenuation steps
`timescale 1ns/10ps
module acdp_vol_ramp (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // control
  input  wire logic       tick_i,
  input  wire logic       sinc_en_i,
  input  wire logic [7:0] target_i,
  // ramped attenuation
  output logic      [7:0] atten_o
);

  acdp_pkg::acdp_ramp_st_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] att_q, att_d;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    att_d = att_q;
    case (st_q)
      acdp_pkg::RAMP_OFF: begin
        att_d = acdp_pkg::VOL_MUTE;
        cnt_d = '0;
        if (sinc_en_i) begin
          st_d = acdp_pkg::RAMP_RUN;  // R14
        end
      end
      acdp_pkg::RAMP_RUN: begin
        if (att_q == target_i) begin
          st_d = acdp_pkg::RAMP_HOLD;
        end else if (tick_i) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == acdp_pkg::RAMP_LAST) begin
            // one 0.375 dB step toward the programmed level
            att_d = (att_q > target_i) ? att_q - 8'h01 : att_q + 8'h01; // R14
          end
        end
      end
      acdp_pkg::RAMP_HOLD: begin
        if (att_q != target_i) begin
          st_d  = acdp_pkg::RAMP_RUN;
          cnt_d = '0;
        end
      end
      default: st_d = acdp_pkg::RAMP_OFF;
    endcase
    if (!sinc_en_i) begin
      st_d  = acdp_pkg::RAMP_OFF;
      att_d = acdp_pkg::VOL_MUTE;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q  <= acdp_pkg::RAMP_OFF;
      cnt_q <= 4'h0;
      att_q <= acdp_pkg::VOL_MUTE;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      att_q <= att_d;
    end
  end

  assign atten_o = att_q;

endmodule

// File: design/acdp_regs.sv
// adc decimator pair config registers with mute, ramp and mic capture
//
// Behaviour
// R1: second-pair bit 5 picks sinc order for ADC2/3: 0 fourth, 1 third.
// R2: software stops the core before changing the sinc order.
// R3: sinc order and sample rate take effect only while core run is 0.
// R4: bits 4/3 mute ADC3/ADC2 by full attenuation; both reset muted.
// R5: a channel whose volume stage is bypassed ignores its mute bit.
// R6: rate bits 1:0 give 96, 192 or 768 kHz; code 11 is reserved.
// R7: software keeps rate consistent with path rate, never writes code 11.
// R8: second-pair register resets to 0x19.
// R9: first-pair bits 6:5 set ADC0/1 high-pass: off, 1, 4, 8 Hz.
// R10: mic polarity clear: 0 positive; set: 1 positive.
// R11: swap clear: left on rising, right on falling mic clock edge.
// R12: bit 2 feeds ADC0/1 decimators from converters (0) or mics (1).
// R13: software pairs ADC0/1 enables with their sinc enables.
// R14: a set sinc enable ramps volume from full attenuation, 16 periods a step.
// R15: reserved bits store, read back, do nothing and reset to zero.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module acdp_regs (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  // register port
  input  wire logic [7:0]            addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [7:0]            rdata_o,
  // core and neighbouring registers
  input  wire logic                  core_run_i,
  input  wire logic [1:0]            pair01_rate_i,
  input  wire logic [3:0]            sinc_en_i,
  input  wire logic [1:0]            mute01_i,
  input  wire logic [3:0]            vol_bypass_i,
  input  wire logic [31:0]           vol_target_i,
  // converter modulator bits for ADC0/1
  input  wire logic [1:0]            adc01_bit_i,
  input  wire logic                  adc01_valid_i,
  // digital microphone pins
  input  wire logic                  mic01_clk_i,
  input  wire logic                  mic01_data_i,
  // settings in force
  output acdp_pkg::acdp_pair23_t     pair23_cfg_o,
  output acdp_pkg::acdp_pair01_t     pair01_cfg_o,
  output logic      [31:0]           vol_atten_o,
  // decimator input for ADC0/1
  output logic      [1:0]            decim01_bit_o,
  output logic      [1:0]            decim01_valid_o
);

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  logic [7:0] pair23_q, pair23_d;
  logic [7:0] pair01_q, pair01_d;
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    pair23_d = pair23_q;
    pair01_d = pair01_q;
    rdata_d  = acdp_pkg::RDATA_NONE;
    // all eight bits stored, reserved ones included
    if (wr_i && addr_i == acdp_pkg::OFS_PAIR23) begin
      pair23_d = wdata_i;  // R15
    end
    if (wr_i && addr_i == acdp_pkg::OFS_PAIR01) begin
      pair01_d = wdata_i;  // R15
    end
    if (rd_i) begin
      case (addr_i)
        acdp_pkg::OFS_PAIR23: rdata_d = pair23_q;
        acdp_pkg::OFS_PAIR01: rdata_d = pair01_q;
        default:              rdata_d = acdp_pkg::RDATA_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pair23_q <= acdp_pkg::RST_PAIR23;  // R8
      pair01_q <= acdp_pkg::RST_PAIR01;  // R15
      rdata_q  <= acdp_pkg::RDATA_NONE;
    end else begin
      pair23_q <= pair23_d;
      pair01_q <= pair01_d;
      rdata_q  <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // settings in force on the decimators

  acdp_pkg::acdp_pair23_t cfg23_q, cfg23_d;
  acdp_pkg::acdp_pair01_t cfg01_q, cfg01_d;
  acdp_pkg::acdp_rate_t   wr_rate;

  always_comb begin
    wr_rate = acdp_pkg::acdp_rate_t'(pair23_q[acdp_pkg::P23_RATE_LO +: 2]);
    cfg23_d = cfg23_q;
    // a running core keeps its filter shape; the change waits for a stop
    if (!core_run_i) begin  // R3
      cfg23_d.sinc_third = pair23_q[acdp_pkg::P23_SINC];  // R1
      // the reserved code never reaches the decimators
      if (wr_rate != acdp_pkg::RATE_RSVD) begin
        cfg23_d.rate = wr_rate;  // R6
      end
    end
    cfg01_d.hp         = acdp_pkg::acdp_hp_t'(
                           pair01_q[acdp_pkg::P01_HP_LO +: 2]);  // R9
    cfg01_d.mic_source = pair01_q[acdp_pkg::P01_SRC];  // R12
    cfg01_d.adc_en     = {pair01_q[acdp_pkg::P01_EN1],
                          pair01_q[acdp_pkg::P01_EN0]};
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg23_q <= acdp_pkg::acdp_pair23_t'(
                   {acdp_pkg::RST_PAIR23[acdp_pkg::P23_SINC],
                    acdp_pkg::RST_PAIR23[acdp_pkg::P23_RATE_LO +: 2]});
      cfg01_q <= '0;
    end else begin
      cfg23_q <= cfg23_d;
      cfg01_q <= cfg01_d;
    end
  end

  assign pair23_cfg_o = cfg23_q;
  assign pair01_cfg_o = cfg01_q;

  ////////////////////////////////////////////////////////////////////////////
  // sample-rate enables, one per pair

  function automatic logic [7:0] rate_div(input logic [1:0] rate);
    case (rate)
      acdp_pkg::RATE_96K:  rate_div = acdp_pkg::DIV_96;
      acdp_pkg::RATE_768K: rate_div = acdp_pkg::DIV_768;
      default:             rate_div = acdp_pkg::DIV_192;
    endcase
  endfunction

  logic [7:0] div01_q, div01_d;
  logic [7:0] div23_q, div23_d;
  logic       tick01_q, tick01_d;
  logic       tick23_q, tick23_d;

  always_comb begin
    tick01_d = 1'b0;
    tick23_d = 1'b0;
    div01_d  = div01_q + 8'h01;
    div23_d  = div23_q + 8'h01;
    // the fractional part of the ratio is dropped; the ramp pace is
    // within one percent of nominal
    if (div01_q >= rate_div(pair01_rate_i) - 8'h01) begin
      div01_d  = '0;
      tick01_d = 1'b1;
    end
    if (div23_q >= rate_div(cfg23_q.rate) - 8'h01) begin
      div23_d  = '0;
      tick23_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div01_q  <= 8'h00;
      div23_q  <= 8'h00;
      tick01_q <= 1'b0;
      tick23_q <= 1'b0;
    end else begin
      div01_q  <= div01_d;
      div23_q  <= div23_d;
      tick01_q <= tick01_d;
      tick23_q <= tick23_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // volume ramps, mute and bypass

  logic [31:0] ramp_att;
  logic [3:0]  mute_all;
  logic [3:0]  ch_tick;
  logic [31:0] vol_q, vol_d;

  assign ch_tick  = {tick23_q, tick23_q, tick01_q, tick01_q};
  assign mute_all = {pair23_q[acdp_pkg::P23_MUTE3],
                     pair23_q[acdp_pkg::P23_MUTE2],
                     mute01_i};

  for (genvar ch = 0; ch < 4; ch++) begin : g_ramp
    acdp_vol_ramp u_ramp (
      .clk_i     (clk_i),
      .resetn_i  (resetn_i),
      .tick_i    (ch_tick[ch]),
      .sinc_en_i (sinc_en_i[ch]),
      .target_i  (vol_target_i[8*ch +: 8]),
      .atten_o   (ramp_att[8*ch +: 8])
    );
  end

  always_comb begin
    for (int ch = 0; ch < 4; ch++) begin
      if (vol_bypass_i[ch]) begin
        // a bypassed stage passes the signal untouched, mute or not
        vol_d[8*ch +: 8] = acdp_pkg::VOL_UNITY;  // R5
      end else if (mute_all[ch]) begin
        vol_d[8*ch +: 8] = acdp_pkg::VOL_MUTE;  // R4
      end else begin
        vol_d[8*ch +: 8] = ramp_att[8*ch +: 8];  // R14
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vol_q <= {4{acdp_pkg::VOL_MUTE}};
    end else begin
      vol_q <= vol_d;
    end
  end

  assign vol_atten_o = vol_q;

  ////////////////////////////////////////////////////////////////////////////
  // microphone pin synchronisers

  logic mclk_s1_q, mclk_s2_q, mclk_prev_q;
  logic mdat_s1_q, mdat_s2_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mclk_s1_q   <= 1'b0;
      mclk_s2_q   <= 1'b0;
      mclk_prev_q <= 1'b0;
      mdat_s1_q   <= 1'b0;
      mdat_s2_q   <= 1'b0;
    end else begin
      mclk_s1_q   <= mic01_clk_i;
      mclk_s2_q   <= mclk_s1_q;
      mclk_prev_q <= mclk_s2_q;
      mdat_s1_q   <= mic01_data_i;
      mdat_s2_q   <= mdat_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // microphone capture and decimator source select

  logic       rise, fall;
  logic       mic_pos;
  logic [1:0] dbit_q, dbit_d;
  logic [1:0] dval_q, dval_d;

  assign rise = mclk_s2_q && !mclk_prev_q;
  assign fall = !mclk_s2_q && mclk_prev_q;

  always_comb begin
    // a one means positive: set polarity keeps the level, clear inverts it
    mic_pos = pair01_q[acdp_pkg::P01_POL] ? mdat_s2_q : !mdat_s2_q;  // R10
    dbit_d  = dbit_q;
    dval_d  = 2'b00;
    if (cfg01_q.mic_source) begin  // R12
      // left is slot 0, right is slot 1; the swap trades the edges
      if (rise) begin
        if (pair01_q[acdp_pkg::P01_SWAP]) begin  // R11
          dbit_d[1] = mic_pos;
          dval_d[1] = 1'b1;
        end else begin
          dbit_d[0] = mic_pos;
          dval_d[0] = 1'b1;
        end
      end
      if (fall) begin
        if (pair01_q[acdp_pkg::P01_SWAP]) begin  // R11
          dbit_d[0] = mic_pos;
          dval_d[0] = 1'b1;
        end else begin
          dbit_d[1] = mic_pos;
          dval_d[1] = 1'b1;
        end
      end
    end else if (adc01_valid_i) begin
      dbit_d = adc01_bit_i;  // R12
      dval_d = 2'b11;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dbit_q <= 2'b00;
      dval_q <= 2'b00;
    end else begin
      dbit_q <= dbit_d;
      dval_q <= dval_d;
    end
  end

  assign decim01_bit_o   = dbit_q;
  assign decim01_valid_o = dval_q;

endmodule

// File: dv/acdp_regs_monitor.sv
// port-level assertions for the adc decimator pair config registers
`timescale 1ns/10ps
module acdp_regs_monitor (
  // clock, reset and register port
  input wire logic              clk_i,
  input wire logic              resetn_i,
  input wire logic [7:0]        addr_i,
  input wire logic [7:0]        wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [7:0]        rdata_o,
  // side inputs
  input wire logic              core_run_i,
  input wire logic [3:0]        sinc_en_i,
  input wire logic [1:0]        mute01_i,
  input wire logic [3:0]        vol_bypass_i,
  input wire logic [1:0]        adc01_bit_i,
  input wire logic              adc01_valid_i,
  // outputs
  input acdp_pkg::acdp_pair23_t pair23_cfg_o,
  input acdp_pkg::acdp_pair01_t pair01_cfg_o,
  input wire logic [31:0]       vol_atten_o,
  input wire logic [1:0]        decim01_bit_o,
  input wire logic [1:0]        decim01_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_w23;
    wr_i && addr_i == acdp_pkg::OFS_PAIR23;
  endsequence
  sequence s_w01;
    wr_i && addr_i == acdp_pkg::OFS_PAIR01;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_cfg_frozen: assert property (
    core_run_i |=> $stable(pair23_cfg_o)) else $error("pair23 moved in run");
  a_cfg23_apply: assert property (
    s_w23 ##0 wdata_i[1:0] != 2'h3 ##1 !core_run_i |=>
    pair23_cfg_o == {$past(wdata_i[5], 2), $past(wdata_i[1:0], 2)})
    else $error("pair23 setting not applied");
  a_rate_rsvd: assert property (
    s_w23 ##0 wdata_i[1:0] == 2'h3 ##1 1'b1 |=> $stable(pair23_cfg_o.rate))
    else $error("reserved rate applied");
  a_cfg01_apply: assert property (
    s_w01 |=> ##1 pair01_cfg_o ==
    {$past(wdata_i[6:5], 2), $past(wdata_i[2:0], 2)})
    else $error("pair01 setting not applied");
  a_mute_full: assert property (
    mute01_i[0] && !vol_bypass_i[0] |=> vol_atten_o[7:0] == 8'hFF)
    else $error("muted channel not at full attenuation");
  // reset is sampled low on its release edge, so the reset value stays out
  a_bypass_unity: assert property (
    resetn_i && vol_bypass_i[3] |=> vol_atten_o[31:24] == 8'h00)
    else $error("bypassed channel not at unity");
  a_sinc_off: assert property (
    !sinc_en_i[2] ##1 !sinc_en_i[2] && !vol_bypass_i[2] |=>
    vol_atten_o[23:16] == 8'hFF) else $error("idle channel not attenuated");
  a_conv_path: assert property (
    adc01_valid_i && !pair01_cfg_o.mic_source |=>
    decim01_valid_o == 2'h3 && decim01_bit_o == $past(adc01_bit_i))
    else $error("converter bits not passed");
  a_mic_quiet: assert property (
    !pair01_cfg_o.mic_source && !adc01_valid_i |=> decim01_valid_o == 2'h0)
    else $error("decimator strobe without source");
  a_rd_idle: assert property (
    !rd_i |=> rdata_o == acdp_pkg::RDATA_NONE) else $error("read data held");
endmodule

bind acdp_regs acdp_regs_monitor mon_u (
  .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .core_run_i(core_run_i),
  .sinc_en_i(sinc_en_i), .mute01_i(mute01_i), .vol_bypass_i(vol_bypass_i),
  .adc01_bit_i(adc01_bit_i), .adc01_valid_i(adc01_valid_i),
  .pair23_cfg_o(pair23_cfg_o), .pair01_cfg_o(pair01_cfg_o),
  .vol_atten_o(vol_atten_o), .decim01_bit_o(decim01_bit_o),
  .decim01_valid_o(decim01_valid_o)
);

// File: dv/adc_decimator_pair_config_tb_top.sv
// self-checking bench for the adc decimator pair config registers
`timescale 1ns/10ps
module adc_decimator_pair_config_tb_top;
  localparam int STEP = 16 * int'(acdp_pkg::DIV_768);
  logic                   clk_i;
  logic                   resetn_i;
  logic [7:0]             addr_i;
  logic [7:0]             wdata_i;
  logic                   wr_i;
  logic                   rd_i;
  logic [7:0]             rdata_o;
  logic                   core_run_i;
  logic [3:0]             sinc_en_i;
  logic [3:0]             vol_bypass_i;
  logic [31:0]            vol_target_i;
  logic [31:0]            vol_atten_o;
  logic [1:0]             adc01_bit_i;
  logic                   adc01_valid_i;
  logic                   mic01_clk_i;
  logic                   mic01_data_i;
  logic [1:0]             decim01_bit_o;
  logic [1:0]             decim01_valid_o;
  acdp_pkg::acdp_pair23_t pair23_cfg_o;
  acdp_pkg::acdp_pair01_t pair01_cfg_o;
  int                     fail_count;
  int                     n_tests;
  int                     n;

  acdp_regs dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .core_run_i(core_run_i),
    .pair01_rate_i(2'h1), .sinc_en_i(sinc_en_i), .mute01_i(2'h1),
    .vol_bypass_i(vol_bypass_i), .vol_target_i(vol_target_i),
    .adc01_bit_i(adc01_bit_i), .adc01_valid_i(adc01_valid_i),
    .mic01_clk_i(mic01_clk_i), .mic01_data_i(mic01_data_i),
    .pair23_cfg_o(pair23_cfg_o), .pair01_cfg_o(pair01_cfg_o),
    .vol_atten_o(vol_atten_o), .decim01_bit_o(decim01_bit_o),
    .decim01_valid_o(decim01_valid_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  // settings need one edge into the register and one more to be applied
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    settle();
  endtask

  task automatic rd(input logic [7:0] a, exp, input string nm);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, rdata_o, exp);
  endtask

  task automatic wait_vol(input logic [7:0] v);
    n = 0;
    while (vol_atten_o[23:16] === v && n < 2000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n == 2000) begin
      chk("volume wait", 8'h01, 8'h00);
      complete_run();
    end
  endtask

  task automatic mic(input logic lvl, dat, input logic [1:0] ev, eb);
    @(posedge clk_i);
    mic01_clk_i <= lvl;
    mic01_data_i <= dat;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (decim01_valid_o === 2'h0 && n < 8);
    chk("mic valid", 8'(decim01_valid_o), 8'(ev));
    chk("mic bit", 8'(decim01_bit_o & ev), 8'(eb));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    fail_count = 0;
    n_tests = 0;
    n = 0;
    resetn_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    core_run_i = 1'b0;
    sinc_en_i = 4'h0;
    vol_bypass_i = 4'h0;
    vol_target_i = 32'h0;
    adc01_bit_i = 2'h0;
    adc01_valid_i = 1'b0;
    mic01_clk_i = 1'b0;
    mic01_data_i = 1'b0;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    settle();
    chk("cfg23 reset", 8'(pair23_cfg_o), 8'h01);
    chk("cfg01 reset", 8'(pair01_cfg_o), 8'h00);
    rd(8'h1C, 8'h19, "reg23 reset");
    rd(8'h1D, 8'h00, "reg01 reset");
    rd(8'h1E, 8'h00, "unmapped read");
    @(posedge clk_i);
    core_run_i <= 1'b1;
    wr(8'h1C, 8'hC6);
    rd(8'h1C, 8'hC6, "reg23 store");
    chk("cfg23 frozen", 8'(pair23_cfg_o), 8'h01);
    @(posedge clk_i);
    core_run_i <= 1'b0;
    settle();
    chk("cfg23 released", 8'(pair23_cfg_o), 8'h02);
    for (int j = 0; j < 6; j++) begin
      wr(8'h1C, 8'(((j & 1) << 5) | (j >> 1)));
      chk("cfg23 apply", 8'(pair23_cfg_o), 8'(((j & 1) << 2) | (j >> 1)));
    end
    wr(8'h1C, 8'h03);
    chk("reserved rate", 8'(pair23_cfg_o), 8'h02);
    wr(8'h1E, 8'hFF);
    rd(8'h1C, 8'h03, "unmapped write");
    for (int j = 0; j < 4; j++) begin
      wr(8'h1D, 8'(8'h98 | (j << 5) | ((j & 1) << 2) | j));
      rd(8'h1D, 8'(8'h98 | (j << 5) | ((j & 1) << 2) | j), "reg01");
      chk("cfg01", 8'(pair01_cfg_o), 8'((j << 3) | ((j & 1) << 2) | j));
    end
    // ramp at the fastest rate keeps the run short
    wr(8'h1C, 8'h02);
    chk("sinc off vol", vol_atten_o[23:16], 8'hFF);
    @(posedge clk_i);
    vol_target_i <= 32'h00FD_0000;
    // channel 0 ramps too, so only its mute keeps it at full attenuation
    sinc_en_i <= 4'h5;
    wait_vol(8'hFF);
    chk("ramp first", vol_atten_o[23:16], 8'hFE);
    wait_vol(8'hFE);
    chk("ramp period", 8'(n == STEP), 8'h01);
    repeat (2 * STEP) @(posedge clk_i);
    #1;
    chk("ramp hold", vol_atten_o[23:16], 8'hFD);
    wr(8'h1C, 8'h0A);
    chk("mute ch2", vol_atten_o[23:16], 8'hFF);
    @(posedge clk_i);
    vol_bypass_i <= 4'hC;
    settle();
    chk("bypass ch2", vol_atten_o[23:16], 8'h00);
    wr(8'h1D, 8'h04);
    mic(1'b1, 1'b1, 2'h1, 2'h0);
    mic(1'b0, 1'b0, 2'h2, 2'h2);
    wr(8'h1D, 8'h1C);
    mic(1'b1, 1'b1, 2'h2, 2'h2);
    mic(1'b0, 1'b0, 2'h1, 2'h0);
    @(posedge clk_i);
    adc01_valid_i <= 1'b1;
    adc01_bit_i <= 2'h2;
    @(posedge clk_i);
    adc01_valid_i <= 1'b0;
    #1;
    chk("conv ignored", 8'(decim01_valid_o), 8'h00);
    wr(8'h1D, 8'h00);
    @(posedge clk_i);
    adc01_valid_i <= 1'b1;
    @(posedge clk_i);
    adc01_valid_i <= 1'b0;
    #1;
    chk("conv valid", 8'(decim01_valid_o), 8'h03);
    chk("conv bits", 8'(decim01_bit_o), 8'h02);
    mic(1'b1, 1'b1, 2'h0, 2'h0);
    chk("mute ch0", vol_atten_o[7:0], 8'hFF);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(8'h1C, 8'h19, "reg23 second reset");
    complete_run();
  end
endmodule
